// *** pkg/aux_timer_pkg.sv ***
// Constants, register map and field layout for the sixteen-bit timer/counter.
// Operation
// - Buffered-access bit set makes high and low bytes a single 16-bit access.
// - Time-base select 01 gives this counter to unit two, other timer to one.
// - Prescale field divides the count clock by 1, 2, 4 or 8.
// - External clock is synchronised either way; sync-disable 1 takes its edge one stage earlier.
// - Internal clock source ignores the sync-disable bit.
// - External source counts rising edges only after the first falling edge.
// - Clock source select clear counts the internal instruction clock.
// - A 16-bit counter runs as a timer or an external event counter.
// - Counter appears as readable and writable high and low byte registers.
// - Special event trigger of an assigned compare unit resets the counter.
// - Counter wraps FFFFh to 0000h and latches an overflow flag.
// - Buffered mode low-byte read copies high byte into buffer read at high.
// - Buffered low-byte write loads high from buffer; any low write or unbuffered high write clears prescaler.
// - A software counter write beats a coincident special event reset.
package aux_timer_pkg;
  localparam int         ADDR_W      = 4;
  localparam int         DATA_W      = 32;
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_LOW     = 4'h4;
  localparam logic [3:0] OFS_HIGH    = 4'h8;
  localparam logic [3:0] OFS_STATUS  = 4'hC;
  localparam logic [3:0] OFS_MASK    = 4'h0;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam int BIT_ON      = 0;
  localparam int BIT_CS      = 1;
  localparam int BIT_NOSYNC  = 2;
  localparam int BIT_TB_LO   = 3;
  localparam int BIT_PS_LO   = 4;
  localparam int BIT_TB_HI   = 6;
  localparam int BIT_BUF     = 7;
  localparam int BIT_OVF     = 0;
  localparam int BIT_MASKSEL = 3;
  localparam logic [2:0] PS_MAX   = 3'h7;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_RST = 16'h0000;
endpackage

// *** logic/aux_timer.sv ***
// Sixteen-bit timer/counter with Avalon-MM register slave.
//
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
module aux_timer
  import aux_timer_pkg::*;
(
  // Clock, reset and clock enable.
  input  wire logic                              mclk_i,
  input  wire logic                              rstn_i,
  input  wire logic                              ce_i,
  // Avalon-MM slave.
  input  wire logic [aux_timer_pkg::ADDR_W-1:0]  avs_address_i,
  input  wire logic                              avs_read_i,
  input  wire logic                              avs_write_i,
  input  wire logic [aux_timer_pkg::DATA_W-1:0]  avs_writedata_i,
  input  wire logic [3:0]                        avs_byteenable_i,
  output logic      [aux_timer_pkg::DATA_W-1:0]  avs_readdata_o,
  output logic                                   avs_waitrequest_o,
  // Clock sources and compare-unit triggers.
  input  wire logic                              ext_count_pin_i,
  input  wire logic                              lp_osc_i,
  input  wire logic                              lp_osc_en_i,
  input  wire logic                              sevt_unit1_i,
  input  wire logic                              sevt_unit2_i,
  // Outputs.
  output logic                                   unit1_this_timer_o,
  output logic                                   unit2_this_timer_o,
  output logic      [15:0]                       count_o,
  output logic                                   irq_o
);
  import aux_timer_pkg::*;

  logic [7:0]  control_ff, nxt_control;
  logic [15:0] count_ff, nxt_count;
  logic [7:0]  hibuf_ff, nxt_hibuf;
  logic [2:0]  pre_ff, nxt_pre;
  logic        status_ff, nxt_status;
  logic        mask_ff, nxt_mask;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        ack_ff, nxt_ack;
  logic        ext_s1_ff, ext_s2_ff, ext_s3_ff, ext_s4_ff;
  logic        armed_ff, nxt_armed;

  logic        req, wr, rd, sel_lo, sel_hi, ext_raw, ext_prev, ext_cur;
  logic        tick_src, tick, wrap, sevt, cnt_wr, wr_b0;
  logic [1:0]  tb;
  logic [2:0]  pre_div;

  assign req    = (avs_read_i | avs_write_i) & ~ack_ff;
  assign wr     = avs_write_i & req & ce_i;
  assign rd     = avs_read_i & req & ce_i;
  assign wr_b0  = wr & avs_byteenable_i[0];
  assign sel_lo = avs_address_i == OFS_LOW;
  assign sel_hi = avs_address_i == OFS_HIGH;
  assign avs_waitrequest_o = ~ack_ff;
  assign avs_readdata_o    = rdata_ff;

  // External source mux, then a two-stage synchroniser and edge stages.
  assign ext_raw = lp_osc_en_i ? lp_osc_i : ext_count_pin_i;
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_s3_ff <= 1'b0;
      ext_s4_ff <= 1'b0;
    end else if (ce_i) begin
      ext_s1_ff <= ext_raw;
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
      ext_s4_ff <= ext_s3_ff;
    end
  end
  // Unsynchronised mode takes its edge one stage earlier to cut latency.
  assign ext_cur  = ext_s2_ff;
  assign ext_prev = ext_s3_ff;

  always_comb begin
    if (!control_ff[BIT_CS]) begin
      tick_src = 1'b1;
    end else if (control_ff[BIT_NOSYNC]) begin
      tick_src = armed_ff & ext_cur & ~ext_prev;
    end else begin
      tick_src = armed_ff & ext_s3_ff & ~ext_s4_ff;
    end
  end
  // Arm after the first falling edge of the external source.
  assign nxt_armed = control_ff[BIT_CS] &
                     (armed_ff | (ext_prev & ~ext_cur));

  assign pre_div = PS_MAX >> (2'h3 - control_ff[BIT_PS_LO+:2]);
  assign tick    = control_ff[BIT_ON] & tick_src & (pre_ff == pre_div);
  assign wrap    = tick & (count_ff == CNT_MAX);

  assign tb = {control_ff[BIT_TB_HI], control_ff[BIT_TB_LO]};
  always_comb begin
    unit1_this_timer_o = tb[1];
    unit2_this_timer_o = tb[1] | tb[0];
  end
  assign sevt = (sevt_unit1_i & unit1_this_timer_o) |
                (sevt_unit2_i & unit2_this_timer_o);
  assign cnt_wr = wr_b0 & (sel_lo | (sel_hi & ~control_ff[BIT_BUF]));

  always_comb begin
    nxt_control = control_ff;
    nxt_count   = count_ff;
    nxt_hibuf   = hibuf_ff;
    nxt_pre     = pre_ff;
    nxt_status  = status_ff | wrap;
    nxt_mask    = mask_ff;
    nxt_rdata   = 32'h0000_0000;
    nxt_ack     = req & ce_i;
    if (tick) begin
      nxt_count = count_ff + 16'h0001;
      nxt_pre   = 3'h0;
    end else if (control_ff[BIT_ON] & tick_src) begin
      nxt_pre = pre_ff + 3'h1;
    end
    if (sevt & ce_i) begin
      nxt_count = CNT_RST;
      nxt_pre   = 3'h0;
    end
    if (wr_b0) begin
      if (avs_address_i == OFS_CONTROL && !avs_byteenable_i[1]) begin
        nxt_control = avs_writedata_i[7:0];
      end
      if (avs_address_i == OFS_MASK && avs_byteenable_i[1]) begin
        nxt_mask = avs_writedata_i[8 + BIT_OVF];
      end
      if (sel_lo) begin
        nxt_count[7:0] = avs_writedata_i[7:0];
        nxt_pre        = 3'h0;
        if (control_ff[BIT_BUF]) begin
          nxt_count[15:8] = hibuf_ff;
        end else begin
          nxt_count[15:8] = count_ff[15:8];
        end
      end
      if (sel_hi) begin
        if (control_ff[BIT_BUF]) begin
          nxt_hibuf = avs_writedata_i[7:0];
        end else begin
          nxt_count = {avs_writedata_i[7:0], count_ff[7:0]};
        end
      end
    end
    if (rd) begin
      case (avs_address_i)
        OFS_CONTROL: nxt_rdata = {23'h0, mask_ff, control_ff};
        OFS_LOW: begin
          nxt_rdata = {24'h0, count_ff[7:0]};
          if (control_ff[BIT_BUF]) begin
            nxt_hibuf = count_ff[15:8];
          end
        end
        OFS_HIGH: begin
          nxt_rdata = control_ff[BIT_BUF] ? {24'h0, hibuf_ff}
                                          : {24'h0, count_ff[15:8]};
        end
        OFS_STATUS: begin
          nxt_rdata  = {31'h0, status_ff};
          nxt_status = wrap;
        end
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
    if (!control_ff[BIT_ON]) begin
      nxt_pre = 3'h0;
    end
    if (cnt_wr) begin
      nxt_pre = 3'h0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      control_ff <= CONTROL_RST;
      count_ff   <= CNT_RST;
      hibuf_ff   <= 8'h00;
      pre_ff     <= 3'h0;
      status_ff  <= 1'b0;
      mask_ff    <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      ack_ff     <= 1'b0;
      armed_ff   <= 1'b0;
    end else if (ce_i) begin
      control_ff <= nxt_control;
      count_ff   <= nxt_count;
      hibuf_ff   <= nxt_hibuf;
      pre_ff     <= nxt_pre;
      status_ff  <= nxt_status;
      mask_ff    <= nxt_mask;
      rdata_ff   <= nxt_rdata;
      ack_ff     <= nxt_ack;
      armed_ff   <= nxt_armed;
    end else begin
      ack_ff <= 1'b0;
    end
  end

  assign count_o = count_ff;
  assign irq_o   = status_ff & mask_ff;
endmodule // aux_timer

// *** verif/aux_timer_asserts.sv ***
// Port checks for the sixteen-bit timer/counter.
`timescale 1ns/1ps
module aux_timer_asserts (
  input wire logic        mclk_i, rstn_i, avs_read_i, avs_write_i,
  input wire logic        avs_waitrequest_o, sevt_unit1_i, sevt_unit2_i,
  input wire logic        unit1_this_timer_o, unit2_this_timer_o, irq_o,
  input wire logic [3:0]  avs_address_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic [15:0] count_o
);
  logic [1:0] busy_ff;
  always_ff @(posedge mclk_i)
    busy_ff <= {busy_ff[0], avs_write_i | sevt_unit1_i | sevt_unit2_i};
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  sequence taken_s;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  answer_due_a: assert property (taken_s |=> !avs_waitrequest_o)
    else $error("request not answered");
  answer_one_a: assert property (
    !avs_waitrequest_o |=> avs_waitrequest_o) else $error("answer held");
  idle_quiet_a: assert property (
    !avs_read_i && !avs_write_i |=> avs_waitrequest_o) else $error("stray");
  count_step_a: assert property (
    !$stable(count_o) && busy_ff == 2'h0 |-> count_o == $past(count_o) + 16'h1)
    else $error("count jumped");
  route_order_a: assert property (
    unit1_this_timer_o |-> unit2_this_timer_o) else $error("bad routing");
  route_hold_a: assert property (
    !$stable({unit1_this_timer_o, unit2_this_timer_o}) |-> $past(avs_write_i))
    else $error("routing moved");
  irq_fall_a: assert property (
    $fell(irq_o) |-> $past(avs_read_i) || $past(avs_write_i))
    else $error("irq dropped");
  unmapped_zero_a: assert property (
    !avs_waitrequest_o && avs_read_i && avs_address_i[1:0] != 2'h0
    |-> avs_readdata_o == 32'h0) else $error("unmapped data");
endmodule // aux_timer_asserts
bind aux_timer aux_timer_asserts chk (.*);

// *** verif/ext_source_model.sv ***
// Count source that toggles every third clock while running.
`timescale 1ns/1ps
module ext_source_model (input wire logic mclk_i, run_i, output logic pin_o);
  logic [2:0] tick_ff = 3'h0;
  assign pin_o = tick_ff < 3'h3; // Starts high so a fall comes first.
  always @(posedge mclk_i)
    if (run_i) tick_ff <= (tick_ff == 3'h5) ? 3'h0 : tick_ff + 3'h1;
endmodule // ext_source_model

// *** verif/aux_timer_bench.sv ***
// Self-checking bench for the sixteen-bit timer/counter.
`timescale 1ns/1ps
module aux_timer_bench;
  import aux_timer_pkg::*;
  logic [3:0]  avs_address_i = 4'h0, avs_byteenable_i = 4'h1;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd;
  logic [15:0] count_o, c0, d;
  logic mclk_i = 1'b0, rstn_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic lp_osc_en_i = 1'b0, sevt_unit1_i = 1'b0, sevt_unit2_i = 1'b0;
  logic run = 1'b0, trig = 1'b0, src, avs_waitrequest_o, irq_o;
  logic unit1_this_timer_o, unit2_this_timer_o, ce = 1'b1;
  int errors = 0, total_checks = 0, seed = 46, i, n;
  always #10 mclk_i = !mclk_i;
  aux_timer uut (.mclk_i, .rstn_i, .ce_i(ce), .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
    .avs_waitrequest_o, .ext_count_pin_i(src), .lp_osc_i(src), .lp_osc_en_i,
    .sevt_unit1_i, .sevt_unit2_i, .unit1_this_timer_o, .unit2_this_timer_o,
    .count_o, .irq_o);
  ext_source_model pin_m (.mclk_i, .run_i(run), .pin_o(src));
  task chk(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] v,
           input logic [3:0] be = 4'h1);
    @(posedge mclk_i);
    {avs_address_i, avs_writedata_i, avs_byteenable_i} <= {a, v, be};
    {avs_write_i, avs_read_i, sevt_unit1_i} <= {wr, !wr, trig};
    n = 0;
    do begin
      @(posedge mclk_i);
      sevt_unit1_i <= 1'b0;
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 40);
    if (n >= 40) errors++;
    rd = avs_readdata_o;
    {avs_write_i, avs_read_i} <= 2'b00;
  endtask
  task win(input int cyc, input logic [15:0] exp);
    c0 = count_o;
    repeat (cyc) @(posedge mclk_i);
    chk(16'(count_o - c0), exp);
  endtask
  task summarize;
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk_i);
    errors++;
    summarize;
  end
  initial begin
    repeat (2) @(posedge mclk_i);
    rstn_i <= 1'b1;
    d = $random(seed);
    bus(1'b0, OFS_CONTROL, 0); chk(rd[7:0], CONTROL_RST);
    bus(1'b0, 4'h6, 0); chk(rd, 0);
    for (i = 0; i < 4; i++) begin
      bus(1'b1, OFS_CONTROL, {i[1], 2'b00, i[0], 3'b000});
      chk({unit1_this_timer_o, unit2_this_timer_o}, {i[1], i != 0});
    end
    bus(1'b1, OFS_LOW, d);
    bus(1'b1, OFS_HIGH, d >> 8); chk(count_o, d);
    bus(1'b0, OFS_HIGH, 0); chk(rd[7:0], d[15:8]);
    bus(1'b1, OFS_CONTROL, 32'hC8);
    bus(1'b1, OFS_HIGH, 32'h5A); chk(count_o, d);
    bus(1'b0, OFS_LOW, 0); chk(rd[7:0], d[7:0]);
    bus(1'b0, OFS_HIGH, 0); chk(rd[7:0], d[15:8]);
    bus(1'b1, OFS_HIGH, 32'h3C);
    trig = 1'b1;
    bus(1'b1, OFS_LOW, 32'h96); chk(count_o, 16'h3C96);
    trig = 1'b0;
    sevt_unit2_i <= 1'b1;
    @(posedge mclk_i);
    sevt_unit2_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    chk(count_o, 0);
    for (i = 0; i < 4; i++) begin
      bus(1'b1, OFS_CONTROL, {2'b01, i[1:0], 1'b1, i[0], 2'b01});
      bus(1'b1, OFS_LOW, $random(seed));
      win(64, 16'h40 >> i);
    end
    bus(1'b1, OFS_CONTROL, 32'h48); win(20, 0);
    bus(1'b1, OFS_CONTROL, 32'h49);
    ce <= 1'b0;
    win(20, 16'h1);
    ce <= 1'b1;
    run <= 1'b1;
    for (i = 0; i < 2; i++) begin
      lp_osc_en_i <= i[0];
      bus(1'b1, OFS_CONTROL, {5'b01001, i[0], 2'b11});
      repeat (30) @(posedge mclk_i);
      win(60, 10);
    end
    run <= 1'b0;
    bus(1'b1, OFS_CONTROL, 32'hC9);
    bus(1'b1, OFS_HIGH, 32'hFF);
    bus(1'b1, OFS_LOW, 32'hF0);
    repeat (30) @(posedge mclk_i);
    chk(irq_o, 0);
    bus(1'b1, OFS_MASK, 32'h1C9, 4'h3);
    repeat (2) @(posedge mclk_i);
    chk(irq_o, 1);
    bus(1'b0, OFS_STATUS, 0); chk(rd[0], 1);
    repeat (2) @(posedge mclk_i);
    chk(irq_o, 0);
    summarize;
  end
endmodule // aux_timer_bench
